// ==== pkg/csc_pkg.sv ====
package csc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CSC_ADDR_STATUS = 8'h03;
	localparam logic [7:0] CSC_ADDR_CONFIG = 8'h04;
	localparam logic [7:0] CSC_CFG_RST     = 8'h31;
	localparam logic [7:0] CSC_RD_UNMAPPED = 8'h00;

	// Configuration fields
	localparam int CSC_CFG_TMR_HI  = 7;
	localparam int CSC_CFG_TMR_LO  = 6;
	localparam int CSC_CFG_TMR_EN  = 5;
	localparam int CSC_CFG_SENSOR  = 4;
	localparam int CSC_CFG_RESTART = 3;
	localparam int CSC_CFG_TERMDIS = 2;
	localparam int CSC_CFG_SUSPEND = 1;
	localparam int CSC_CFG_CHG_EN  = 0;

	// Status fields
	localparam int CSC_ST_THERM   = 7;
	localparam int CSC_ST_IPL     = 6;
	localparam int CSC_ST_TSUS    = 5;
	localparam int CSC_ST_TERM    = 4;
	localparam int CSC_ST_RSVD    = 3;
	localparam int CSC_ST_CHG_TO  = 2;
	localparam int CSC_ST_PRE_TO  = 1;
	localparam int CSC_ST_BATF    = 0;

	// ------------------------------------------------------------
	// Synchronised analog status inputs
	// ------------------------------------------------------------
	localparam int CSC_IN_THERM = 0;
	localparam int CSC_IN_IPL   = 1;
	localparam int CSC_IN_TSUS  = 2;
	localparam int CSC_IN_TERM  = 3;
	localparam int CSC_IN_BATF  = 4;
	localparam int CSC_IN_PRE   = 5;
	localparam int CSC_IN_UNDERVOLTAGE_LOCKOUT  = 6;
	localparam int CSC_IN_W     = 7;
	localparam logic [6:0] CSC_FLT_UNDERVOLTAGE_LOCKOUT_MASK = 7'h40;
	localparam logic [6:0] CSC_FLT_ALL_MASK  = 7'h7F;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CSC_CLK_PERIOD_NS = 100;
	localparam int CSC_MINUTE_MS     = 60_000;
	localparam int CSC_MIN_CYCLES    = CSC_MINUTE_MS * (1_000_000 / CSC_CLK_PERIOD_NS);
	localparam int CSC_MIN_CNT_W     = 30;
	localparam int CSC_MIN_PER_HR    = 60;

	localparam int CSC_TO_A_HR = 4;
	localparam int CSC_TO_B_HR = 5;
	localparam int CSC_TO_C_HR = 6;
	localparam int CSC_TO_D_HR = 8;
	localparam int CSC_PRE_MIN = 30;

	localparam int CSC_TMR_W = 9;
	localparam logic [8:0] CSC_TO_A_MIN = 9'(CSC_TO_A_HR * CSC_MIN_PER_HR);
	localparam logic [8:0] CSC_TO_B_MIN = 9'(CSC_TO_B_HR * CSC_MIN_PER_HR);
	localparam logic [8:0] CSC_TO_C_MIN = 9'(CSC_TO_C_HR * CSC_MIN_PER_HR);
	localparam logic [8:0] CSC_TO_D_MIN = 9'(CSC_TO_D_HR * CSC_MIN_PER_HR);
	localparam logic [8:0] CSC_PRE_LIM  = 9'(CSC_PRE_MIN);

endpackage

// ==== pkg/csc_timer_if.sv ====
`timescale 1ns/100ps
interface csc_timer_if;
	import csc_pkg::*;

	logic                 clr;
	logic                 adv;
	logic [CSC_TMR_W-1:0] limit;
	logic                 expired;

	modport ctrl (output clr, output adv, output limit, input expired);
	modport tmr  (input clr, input adv, input limit, output expired);
endinterface

// ==== core/csc_charge_timer.sv ====
`timescale 1ns/100ps
module csc_charge_timer
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	// Control
	csc_timer_if.tmr  tif
);

	logic [CSC_TMR_W-1:0] cnt_r;
	logic [CSC_TMR_W-1:0] cnt_nxt;
	logic                 exp_r;
	logic                 exp_nxt;
	logic                 hit;

	// One minute tick per advance; stops once expired
	assign hit     = tif.adv && !exp_r && ((cnt_r + 9'h001) == tif.limit);
	assign cnt_nxt = tif.clr ? '0 : ((tif.adv && !exp_r) ? cnt_r + 9'h001 : cnt_r);
	// Expiry in the same cycle as a clear is kept
	assign exp_nxt = hit | (exp_r & ~tif.clr);

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_r <= '0;
			exp_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign tif.expired = exp_r;

endmodule

// ==== core/csc_charger_regs.sv ====
// Functional notes
// RULE_01 - Status at 0x03, read-only, writes ignored
// RULE_02 - Bit 7 set during thermal current cutback
// RULE_03 - Bit 6 set while input-power-limit loop active
// RULE_04 - Config at 0x04, all bits read/write
// RULE_05 - Timer field bits 7:6; reset value 0x31
// RULE_06 - Undervoltage lockout reloads all defaults
// RULE_07 - Timer codes give 4, 5, 6, 8 hours
// RULE_08 - Software writes reset bit 1 then 0
// RULE_09 - Enable toggle never restarts charge algorithm
// RULE_10 - Suspend bit freezes safety and pre-charge timers
// RULE_11 - Status 5,4,2,1,0 flags; bit 3 zero
`timescale 1ns/100ps
module csc_charger_regs
	import csc_pkg::*;
#(
	parameter int   P_MIN_CYCLES      = CSC_MIN_CYCLES,
	parameter logic P_CHG_EN_DEFAULT  = 1'b1
)
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_arst_n,
	// Register port of the serial interface
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	// Analog charger state, asynchronous
	input  wire logic       i_thermal_reg,
	input  wire logic       i_input_power_limit_loop,
	input  wire logic       i_thermal_suspend,
	input  wire logic       i_term_current,
	input  wire logic       i_battery_temp_fault_flag,
	input  wire logic       i_precharge_phase,
	input  wire logic       i_undervoltage_lockout,
	// Charger control
	output logic            o_charge_on,
	output logic            o_sensor_type,
	output logic      [7:0] o_charger_config_reg
);

	localparam logic [7:0] CFG_RST_V = {CSC_CFG_RST[7:1], P_CHG_EN_DEFAULT};

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [CSC_IN_W-1:0] s1_r;
	logic [CSC_IN_W-1:0] s2_r;
	logic [CSC_IN_W-1:0] s3_r;
	logic [CSC_IN_W-1:0] flt_r;
	logic [CSC_IN_W-1:0] raw_in;
	logic [CSC_IN_W-1:0] agree;
	logic [CSC_IN_W-1:0] flt_mask;
	logic [CSC_IN_W-1:0] flt_nxt;
	logic                undervoltage_lockout;

	assign raw_in   = {i_undervoltage_lockout, i_precharge_phase, i_battery_temp_fault_flag,
		i_term_current, i_thermal_suspend, i_input_power_limit_loop, i_thermal_reg};
	assign agree    = ~(s2_r ^ s3_r);
	assign undervoltage_lockout     = flt_r[CSC_IN_UNDERVOLTAGE_LOCKOUT];
	// Live status flags drop to default while lockout holds
	assign flt_mask = undervoltage_lockout ? CSC_FLT_UNDERVOLTAGE_LOCKOUT_MASK : CSC_FLT_ALL_MASK; // see RULE_06
	assign flt_nxt  = ((agree & s3_r) | (~agree & flt_r)) & flt_mask;

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			flt_r <= '0;
		end
		else
		begin
			s1_r  <= raw_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			flt_r <= flt_nxt;
		end
	end

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic       sel_status;
	logic       sel_config;
	logic       wr_cfg;

	assign sel_status = (i_reg_addr == CSC_ADDR_STATUS);
	assign sel_config = (i_reg_addr == CSC_ADDR_CONFIG);
	assign wr_cfg     = i_reg_wr && sel_config; // see RULE_04
	// Status has no write path at all
	assign cfg_nxt    = undervoltage_lockout ? CFG_RST_V : (wr_cfg ? i_reg_wdata : cfg_r); // see RULE_01

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cfg_r <= CFG_RST_V; // see RULE_05
		else
			cfg_r <= cfg_nxt; // see RULE_06
	end

	// ------------------------------------------------------------
	// Safety timers
	// ------------------------------------------------------------
	csc_timer_if fast_if ();
	csc_timer_if pre_if ();

	logic [CSC_MIN_CNT_W-1:0] min_cnt_r;
	logic                     min_tick;
	logic                     run_base;
	logic                     restart_hold;
	logic [CSC_TMR_W-1:0]     fast_limit;
	logic [1:0]               tmr_code;

	assign min_tick     = (min_cnt_r == CSC_MIN_CNT_W'(P_MIN_CYCLES - 1));
	// Held in restart while the reset bit is 1; released by writing 0
	assign restart_hold = cfg_r[CSC_CFG_RESTART] | undervoltage_lockout; // see RULE_08
	// Enable bit is not a restart source, so toggling it keeps counts
	assign run_base     = min_tick & cfg_r[CSC_CFG_TMR_EN] & o_charge_on
		& ~cfg_r[CSC_CFG_SUSPEND] & ~undervoltage_lockout; // see RULE_10
	assign tmr_code     = cfg_r[CSC_CFG_TMR_HI:CSC_CFG_TMR_LO];
	assign fast_limit   = (tmr_code == 2'h0) ? CSC_TO_A_MIN :
		(tmr_code == 2'h1) ? CSC_TO_B_MIN :
		(tmr_code == 2'h2) ? CSC_TO_C_MIN : CSC_TO_D_MIN; // see RULE_07

	assign fast_if.clr   = restart_hold; // see RULE_09
	assign fast_if.adv   = run_base & ~flt_r[CSC_IN_PRE];
	assign fast_if.limit = fast_limit;
	assign pre_if.clr    = restart_hold;
	assign pre_if.adv    = run_base & flt_r[CSC_IN_PRE];
	assign pre_if.limit  = CSC_PRE_LIM;

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			min_cnt_r <= '0;
		else if (min_tick)
			min_cnt_r <= '0;
		else
			min_cnt_r <= min_cnt_r + 30'h0000_0001;
	end

	csc_charge_timer u_fast_timer
	(
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.tif       (fast_if.tmr)
	);

	csc_charge_timer u_pre_timer
	(
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.tif       (pre_if.tmr)
	);

	// ------------------------------------------------------------
	// Status, read data and charger control
	// ------------------------------------------------------------
	logic [7:0] status_w;
	logic [7:0] rd_sel;
	logic [7:0] rdata_r;
	logic       timeout;
	logic       chg_on_r;
	logic       chg_on_nxt;

	assign status_w = {flt_r[CSC_IN_THERM],      // see RULE_02
		flt_r[CSC_IN_IPL],                        // see RULE_03
		flt_r[CSC_IN_TSUS], flt_r[CSC_IN_TERM],
		1'b0, fast_if.expired, pre_if.expired,
		flt_r[CSC_IN_BATF]};                      // see RULE_11
	assign rd_sel   = sel_status ? status_w : (sel_config ? cfg_r : CSC_RD_UNMAPPED);
	assign timeout  = fast_if.expired | pre_if.expired;
	// Termination disable keeps charging past timers and taper current
	assign chg_on_nxt = cfg_r[CSC_CFG_CHG_EN] & ~restart_hold & ~cfg_r[CSC_CFG_SUSPEND]
		& ~flt_r[CSC_IN_TSUS] & ~flt_r[CSC_IN_BATF]
		& (cfg_r[CSC_CFG_TERMDIS] | ~(timeout | flt_r[CSC_IN_TERM]));

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rdata_r  <= 8'h00;
			chg_on_r <= 1'b0;
		end
		else
		begin
			rdata_r  <= i_reg_rd ? rd_sel : rdata_r;
			chg_on_r <= chg_on_nxt;
		end
	end

	assign o_reg_rdata          = rdata_r;
	assign o_charge_on          = chg_on_r;
	assign o_sensor_type        = cfg_r[CSC_CFG_SENSOR];
	assign o_charger_config_reg = cfg_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_arst_n);

	property p_status_wr_ignored;
		(i_reg_wr && sel_status && !undervoltage_lockout) |=> (cfg_r == $past(cfg_r));
	endproperty
	a_status_wr_ignored: assert property (p_status_wr_ignored) // see RULE_01
		else $error("status write changed configuration");

	property p_therm_bit;
		(i_reg_rd && sel_status) |=> (o_reg_rdata[7] == $past(flt_r[CSC_IN_THERM]));
	endproperty
	a_therm_bit: assert property (p_therm_bit) // see RULE_02
		else $error("thermal regulation bit wrong");

	property p_ipl_bit;
		(i_reg_rd && sel_status) |=> (o_reg_rdata[6] == $past(flt_r[CSC_IN_IPL]));
	endproperty
	a_ipl_bit: assert property (p_ipl_bit) // see RULE_03
		else $error("power limit bit wrong");

	property p_cfg_write;
		(wr_cfg && !undervoltage_lockout) |=> (o_charger_config_reg == $past(i_reg_wdata));
	endproperty
	a_cfg_write: assert property (p_cfg_write) // see RULE_04
		else $error("configuration write lost");

	property p_undervoltage_lockout_reload;
		undervoltage_lockout |=> (cfg_r == CFG_RST_V) && (status_w == 8'h00);
	endproperty
	a_undervoltage_lockout_reload: assert property (p_undervoltage_lockout_reload) // see RULE_06
		else $error("lockout did not reload defaults");

	property p_limit_map;
		(tmr_code == 2'h3) |-> (fast_if.limit == 9'h1E0);
	endproperty
	a_limit_map: assert property (p_limit_map) // see RULE_07
		else $error("eight hour code not mapped");

	property p_enable_no_restart;
		(!cfg_r[CSC_CFG_RESTART] && !undervoltage_lockout) |-> !fast_if.clr && !pre_if.clr;
	endproperty
	a_enable_no_restart: assert property (p_enable_no_restart) // see RULE_09
		else $error("timers cleared without reset bit");

	property p_suspend_freeze;
		cfg_r[CSC_CFG_SUSPEND] |-> !fast_if.adv && !pre_if.adv;
	endproperty
	a_suspend_freeze: assert property (p_suspend_freeze) // see RULE_10
		else $error("timer advanced while suspended");

	property p_rsvd_zero;
		(i_reg_rd && sel_status) |=> (o_reg_rdata[CSC_ST_RSVD] == 1'b0)
			&& (o_reg_rdata[CSC_ST_CHG_TO] == $past(fast_if.expired));
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // see RULE_11
		else $error("status bits 3 or 2 wrong");

	property p_restart_clears;
		(cfg_r[CSC_CFG_RESTART] && !fast_if.adv) ##1 cfg_r[CSC_CFG_RESTART]
			|-> !fast_if.expired;
	endproperty
	a_restart_clears: assert property (p_restart_clears) // see RULE_08
		else $error("restart did not clear timeout");

	c_cfg_write: cover property (wr_cfg ##1 (i_reg_rd && sel_config));
	c_fast_timeout: cover property ($rose(fast_if.expired));
	c_undervoltage_lockout: cover property ($rose(undervoltage_lockout));
	c_suspend: cover property (cfg_r[CSC_CFG_SUSPEND] && min_tick);

endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
	import csc_pkg::*;

	// ------------------------------------------------------------
	// Bench state
	// ------------------------------------------------------------
	localparam int MC   = 4;
	localparam int CEIL = 20_000;

	logic       i_clk_sys;
	logic       i_arst_n;
	logic [7:0] i_reg_addr;
	logic       i_reg_wr;
	logic       i_reg_rd;
	logic [7:0] i_reg_wdata;
	logic [7:0] o_reg_rdata;
	logic [6:0] pins;
	logic       o_charge_on;
	logic       o_sensor_type;
	logic [7:0] o_charger_config_reg;
	logic [7:0] rv;
	logic [7:0] d;
	int         n_mismatch;
	int         num_checks;
	int         cyc;

	csc_charger_regs #(.P_MIN_CYCLES(MC), .P_CHG_EN_DEFAULT(1'b1)) i_csc_charger_regs (
		.i_clk_sys                 (i_clk_sys),
		.i_arst_n                  (i_arst_n),
		.i_reg_addr                (i_reg_addr),
		.i_reg_wr                  (i_reg_wr),
		.i_reg_rd                  (i_reg_rd),
		.i_reg_wdata               (i_reg_wdata),
		.o_reg_rdata               (o_reg_rdata),
		.i_thermal_reg             (pins[CSC_IN_THERM]),
		.i_input_power_limit_loop  (pins[CSC_IN_IPL]),
		.i_thermal_suspend         (pins[CSC_IN_TSUS]),
		.i_term_current            (pins[CSC_IN_TERM]),
		.i_battery_temp_fault_flag (pins[CSC_IN_BATF]),
		.i_precharge_phase         (pins[CSC_IN_PRE]),
		.i_undervoltage_lockout    (pins[CSC_IN_UNDERVOLTAGE_LOCKOUT]),
		.o_charge_on               (o_charge_on),
		.o_sensor_type             (o_sensor_type),
		.o_charger_config_reg      (o_charger_config_reg)
	);

	// ------------------------------------------------------------
	// Expectations and bus tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] exp_status(input logic [6:0] p);
		exp_status = 8'h00;
		exp_status[CSC_ST_THERM] = p[CSC_IN_THERM];
		exp_status[CSC_ST_IPL]   = p[CSC_IN_IPL];
		exp_status[CSC_ST_TSUS]  = p[CSC_IN_TSUS];
		exp_status[CSC_ST_TERM]  = p[CSC_IN_TERM];
		exp_status[CSC_ST_BATF]  = p[CSC_IN_BATF];
	endfunction

	function automatic int lim_min(input logic [1:0] code);
		case (code)
			2'd0:    lim_min = 4 * 60;
			2'd1:    lim_min = 5 * 60;
			2'd2:    lim_min = 6 * 60;
			default: lim_min = 8 * 60;
		endcase
	endfunction

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	// Strobe is lowered a full cycle before the next access may raise it
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_reg_addr  = a;
		i_reg_wdata = v;
		i_reg_wr    = 1'b1;
		tick(1);
		i_reg_wr = 1'b0;
		tick(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		i_reg_addr = a;
		i_reg_rd   = 1'b1;
		tick(1);
		i_reg_rd = 1'b0;
		v = o_reg_rdata;
		tick(1);
	endtask

	// Read window straddles the expiry tick; tick phase is free running
	task automatic run_fast(input logic [1:0] code);
		int t;
		t = lim_min(code) * MC;
		d = {code, 6'h31};
		wr(CSC_ADDR_CONFIG, d | 8'h08);
		wr(CSC_ADDR_CONFIG, d);
		tick(t - 12);
		rd(CSC_ADDR_STATUS, rv);
		chk("fast_to_early", 8'h00, rv & 8'h04);
		chk("charge_on_run", 8'h01, {7'h00, o_charge_on});
		tick(16);
		rd(CSC_ADDR_STATUS, rv);
		chk("fast_to_late", 8'h04, rv & 8'h04);
		chk("charge_on_to", 8'h00, {7'h00, o_charge_on});
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	always @(posedge i_clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == CEIL)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	initial
	begin
		n_mismatch  = 0;
		num_checks  = 0;
		cyc         = 0;
		i_arst_n    = 1'b0;
		i_reg_addr  = 8'h00;
		i_reg_wr    = 1'b0;
		i_reg_rd    = 1'b0;
		i_reg_wdata = 8'h00;
		pins        = 7'h00;
		void'($urandom(98029));
		repeat (16) @(posedge i_clk_sys);
		#1;
		i_arst_n = 1'b1;
		tick(1);
		chk("cfg_port_rst", CSC_CFG_RST, o_charger_config_reg);
		chk("sensor_rst", 8'h01, {7'h00, o_sensor_type});
		rd(CSC_ADDR_CONFIG, rv);
		chk("cfg_rd_rst", CSC_CFG_RST, rv);
		for (int i = 0; i < 8; i++)
		begin
			pins = (i == 0) ? 7'h1F : 7'($urandom) & 7'h1F;
			tick(6);
			rd(CSC_ADDR_STATUS, rv);
			chk("status_live", exp_status(pins), rv);
		end
		pins = 7'h00;
		wr(CSC_ADDR_CONFIG, 8'hC6);
		pins[CSC_IN_THERM] = 1'b1;
		pins[CSC_IN_UNDERVOLTAGE_LOCKOUT]  = 1'b1;
		tick(6);
		chk("cfg_undervoltage_lockout", CSC_CFG_RST, o_charger_config_reg);
		rd(CSC_ADDR_STATUS, rv);
		chk("status_undervoltage_lockout", 8'h00, rv);
		pins[CSC_IN_UNDERVOLTAGE_LOCKOUT] = 1'b0;
		tick(6);
		rd(CSC_ADDR_STATUS, rv);
		chk("status_after", 8'h80, rv);
		pins = 7'h00;
		for (int i = 0; i < 16; i++)
		begin
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			wr(CSC_ADDR_CONFIG, d);
			rd(CSC_ADDR_CONFIG, rv);
			chk("cfg_rw", d, rv);
			chk("cfg_port", d, o_charger_config_reg);
			chk("sensor", {7'h00, d[4]}, {7'h00, o_sensor_type});
		end
		wr(CSC_ADDR_STATUS, 8'hFF);
		rd(CSC_ADDR_STATUS, rv);
		chk("status_ro", 8'h00, rv);
		wr(8'h05, 8'h5A);
		chk("cfg_unmapped_wr", d, o_charger_config_reg);
		rd(8'h05, rv);
		chk("unmapped_rd", CSC_RD_UNMAPPED, rv);
		for (int c = 0; c < 4; c++)
			run_fast(2'(c));
		// Termination disable charges on although the timeout flag stays set
		wr(CSC_ADDR_CONFIG, 8'hF5);
		chk("charge_on_termdis", 8'h01, {7'h00, o_charge_on});
		rd(CSC_ADDR_STATUS, rv);
		chk("fast_to_sticky", 8'h04, rv & 8'h04);
		pins[CSC_IN_PRE] = 1'b1;
		wr(CSC_ADDR_CONFIG, 8'h39);
		wr(CSC_ADDR_CONFIG, 8'h31);
		tick(40);
		wr(CSC_ADDR_CONFIG, 8'h33);
		tick(200);
		rd(CSC_ADDR_STATUS, rv);
		chk("pre_suspended", 8'h00, rv & 8'h02);
		wr(CSC_ADDR_CONFIG, 8'h31);
		wr(CSC_ADDR_CONFIG, 8'h30);
		wr(CSC_ADDR_CONFIG, 8'h31);
		tick(40);
		rd(CSC_ADDR_STATUS, rv);
		chk("pre_not_yet", 8'h00, rv & 8'h02);
		tick(40);
		rd(CSC_ADDR_STATUS, rv);
		chk("pre_expired", 8'h02, rv & 8'h02);
		pins = 7'h00;
		// Mid-run reset must reload defaults and drop timeout and read data
		wr(CSC_ADDR_CONFIG, 8'hC6);
		i_arst_n = 1'b0;
		tick(2);
		chk("cfg_mid_rst", CSC_CFG_RST, o_charger_config_reg);
		chk("rdata_mid_rst", 8'h00, o_reg_rdata);
		chk("charge_on_mid_rst", 8'h00, {7'h00, o_charge_on});
		i_arst_n = 1'b1;
		tick(1);
		rd(CSC_ADDR_STATUS, rv);
		chk("status_mid_rst", 8'h00, rv);
		end_sim();
	end
endmodule
